// [logic/rap_ctrl.sv]
`timescale 1ns/1ps
`default_nettype none
module rap_ctrl
    import rap_pkg::*;
#(
    parameter int MS_TICK = MS_CYCLES
) (
    input wire logic ref_clk, // System clock
    input wire logic rst, // Synchronous reset
    input wire logic [3:0] s_axi_awaddr, // Write address
    input wire logic s_axi_awvalid, // Write address valid
    output logic s_axi_awready, // Write address ready
    input wire logic [31:0] s_axi_wdata, // Write data
    input wire logic [3:0] s_axi_wstrb, // Write strobes
    input wire logic s_axi_wvalid, // Write data valid
    output logic s_axi_wready, // Write data ready
    output logic [1:0] s_axi_bresp, // Write response
    output logic s_axi_bvalid, // Write response valid
    input wire logic s_axi_bready, // Write response ready
    input wire logic [3:0] s_axi_araddr, // Read address
    input wire logic s_axi_arvalid, // Read address valid
    output logic s_axi_arready, // Read address ready
    output logic [31:0] s_axi_rdata, // Read data
    output logic [1:0] s_axi_rresp, // Read response
    output logic s_axi_rvalid, // Read data valid
    input wire logic s_axi_rready, // Read data ready
    input wire logic sliced_data, // Sliced data from demodulator
    input wire logic bw_select_pin_lo, // Bandwidth select pin, low bit
    input wire logic bw_select_pin_hi, // Bandwidth select pin, high bit
    output logic data_out, // Gated data output
    output logic rx_awake, // Receiver powered up
    output logic desense_en, // Gain reduction on
    output logic [1:0] desense_code, // Gain reduction step
    output logic [1:0] bw_code, // Demodulator bandwidth
    output logic [1:0] slice_code, // Slicing threshold select
    output logic fast_bw, // Fast bandwidth range
    output logic rssi_offset_en, // Signal-strength offset on
    output logic squelch_active // Squelch holding output
);
    logic [19:0] cfg;
    logic cfg_loaded;
    logic [3:0] awaddr_q;
    logic aw_held;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic w_held;
    logic do_write;
    logic [19:0] next_cfg;
    logic poll_arm;
    logic [2:0] data_sync;
    logic [1:0] pin_sync0;
    logic [1:0] pin_sync1;
    logic edge_seen;
    logic [16:0] ms_div;
    logic ms_tick;
    rap_state_t state;
    logic [10:0] sleep_cnt;
    logic [10:0] sleep_ms;
    logic [4:0] wd_cnt;
    logic [4:0] wd_ms;
    logic [15:0] phase_cnt;
    logic [15:0] win_cyc;
    logic phase_bad;
    logic high_bad;
    logic timing;
    logic [1:0] bad_cnt;
    logic [3:0] good_cnt;
    logic [3:0] good_need;
    logic [7:0] sq_hist;
    logic [3:0] sq_pop;
    logic bit_done;
    logic bit_good;
    logic pass;

    // Write channel: address and data taken in either order
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready = !w_held && !s_axi_bvalid;
    assign do_write = aw_held && w_held && !s_axi_bvalid;
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            awaddr_q <= 4'h0;
            wdata_q <= 32'h0;
            wstrb_q <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (awaddr_q == ADDR_CONFIG || awaddr_q == ADDR_STATUS) ?
                    2'h0 : 2'h3;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // New word merged from the enabled byte lanes
    always_comb begin
        next_cfg = cfg;
        if (wstrb_q[0]) next_cfg[7:0] = wdata_q[7:0];
        if (wstrb_q[1]) next_cfg[15:8] = wdata_q[15:8];
        if (wstrb_q[2]) next_cfg[19:16] = wdata_q[19:16];
    end

    // Configuration word replaced in a single step
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cfg <= CFG_RESET;
            cfg_loaded <= 1'b0;
            poll_arm <= 1'b0;
        end else begin
            poll_arm <= 1'b0;
            if (do_write && awaddr_q == ADDR_CONFIG) begin
                cfg <= next_cfg;
                cfg_loaded <= 1'b1;
                poll_arm <= next_cfg[F_POLL] && !cfg[F_POLL];
            end
        end
    end

    // Read channel: one cycle to the answer
    assign s_axi_arready = !s_axi_rvalid;
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= 2'h0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= 2'h0;
            s_axi_rdata <= 32'h0;
            case (s_axi_araddr)
                ADDR_CONFIG: s_axi_rdata <= 32'h0;
                ADDR_STATUS: s_axi_rdata <= {22'h0, good_cnt, bw_code, squelch_active,
                    cfg_loaded, state};
                default: s_axi_rresp <= 2'h3;
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // Pin synchronisers
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            data_sync <= 3'h0;
            pin_sync0 <= 2'h3;
            pin_sync1 <= 2'h3;
        end else begin
            data_sync <= {data_sync[1:0], sliced_data};
            pin_sync0 <= {bw_select_pin_hi, bw_select_pin_lo};
            pin_sync1 <= pin_sync0;
        end
    end
    assign edge_seen = data_sync[2] ^ data_sync[1];

    // Static settings driven out of the word, bandwidth from the pins until the word is first written
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            bw_code <= 2'h3;
            desense_en <= 1'b0;
            desense_code <= 2'h0;
            slice_code <= 2'h3;
            fast_bw <= 1'b0;
            rssi_offset_en <= 1'b0;
        end else begin
            bw_code <= cfg_loaded ? cfg[F_BW_LO +: 2] : pin_sync1;
            desense_en <= cfg[F_DES_EN];
            desense_code <= cfg[F_DES_LO +: 2];
            slice_code <= {cfg[F_SLICE_LO + 1], cfg[F_SLICE_LO]};
            fast_bw <= cfg[F_FAST];
            rssi_offset_en <= cfg[F_RSSI];
        end
    end

    // Slow tick standing in for the low-power oscillator, never gated
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ms_div <= 17'h0;
            ms_tick <= 1'b0;
        end else begin
            ms_tick <= 1'b0;
            if (ms_div == 17'(MS_TICK - 1)) begin
                ms_div <= 17'h0;
                ms_tick <= 1'b1;
            end else begin
                ms_div <= ms_div + 17'h1;
            end
        end
    end

    // Derived periods and targets
    always_comb begin
        sleep_ms = SLEEP_BASE_MS << cfg[F_SLEEP_LO +: 3];
        case (bw_code)
            2'h3: wd_ms = WD_MS_FAST;
            2'h2: wd_ms = WD_MS_FAST;
            2'h1: wd_ms = WD_MS_MID;
            default: wd_ms = WD_MS_SLOW;
        endcase
        case (cfg[F_BCNT_LO +: 2])
            2'h1: good_need = 4'h2;
            2'h2: good_need = 4'h4;
            2'h3: good_need = 4'h8;
            default: good_need = 4'h0;
        endcase
        win_cyc = 16'(WIN_US[cfg[F_WIN_LO +: 3]][~bw_code] * CYC_PER_US);
    end

    // Phase length between edges
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            phase_cnt <= 16'h0;
            timing <= 1'b0;
            high_bad <= 1'b0;
        end else if (!rx_awake) begin
            phase_cnt <= 16'h0;
            timing <= 1'b0;
            high_bad <= 1'b0;
        end else if (edge_seen) begin
            phase_cnt <= 16'h0;
            timing <= 1'b1;
            // A high phase whose start was never seen cannot count as good
            if (!data_sync[1]) high_bad <= phase_bad || !timing;
        end else if (phase_cnt != 16'hffff) begin
            phase_cnt <= phase_cnt + 16'h1;
        end
    end
    // Too short a phase is bad, so a window above the edge spacing fails all
    assign phase_bad = timing && (phase_cnt < win_cyc);
    // A bit closes on the rising edge that ends its low phase
    assign bit_done = edge_seen && data_sync[1] && timing;
    assign bit_good = !phase_bad && !high_bad;

    // Polling sequencer
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state <= RAP_AWAKE;
            sleep_cnt <= 11'h0;
            wd_cnt <= 5'h0;
            bad_cnt <= 2'h0;
            good_cnt <= 4'h0;
        end else if (!cfg[F_POLL]) begin
            state <= RAP_AWAKE;
        end else begin
            case (state)
                RAP_AWAKE: begin
                    if (poll_arm) begin
                        state <= RAP_SLEEP;
                        sleep_cnt <= 11'h0;
                    end
                end
                RAP_SLEEP: begin
                    if (ms_tick) sleep_cnt <= sleep_cnt + 11'h1;
                    if (ms_tick && sleep_cnt + 11'h1 >= sleep_ms) begin
                        wd_cnt <= 5'h0;
                        bad_cnt <= 2'h0;
                        good_cnt <= 4'h0;
                        state <= (good_need == 4'h0) ? RAP_RUN : RAP_CHECK;
                    end
                end
                RAP_CHECK: begin
                    if (edge_seen) begin
                        wd_cnt <= 5'h0;
                    end else if (ms_tick) begin
                        wd_cnt <= wd_cnt + 5'h1;
                    end
                    if (edge_seen && phase_bad && bad_cnt + 2'h1 >= BAD_LIMIT) begin
                        state <= RAP_SLEEP;
                        sleep_cnt <= 11'h0;
                    end else if (!cfg[F_WD_DIS] && ms_tick && !edge_seen &&
                                 wd_cnt + 5'h1 >= wd_ms) begin
                        state <= RAP_SLEEP;
                        sleep_cnt <= 11'h0;
                    end else begin
                        if (edge_seen && phase_bad) bad_cnt <= bad_cnt + 2'h1;
                        if (bit_done && bit_good) begin
                            good_cnt <= good_cnt + 4'h1;
                            if (good_cnt + 4'h1 >= good_need) state <= RAP_RUN;
                        end
                    end
                end
                RAP_RUN: begin
                    if (poll_arm) begin
                        state <= RAP_SLEEP;
                        sleep_cnt <= 11'h0;
                    end
                end
                default: state <= RAP_AWAKE;
            endcase
        end
    end
    // Power-up control from a flip-flop, so a two-bit state step cannot glitch it
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rx_awake <= 1'b1;
        end else begin
            rx_awake <= (state != RAP_SLEEP);
        end
    end

    // Squelch history over the last eight bits
    always_comb begin
        sq_pop = 4'h0;
        for (int i = 0; i < 8; i++) begin
            sq_pop = sq_pop + {3'h0, sq_hist[i]};
        end
    end
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            sq_hist <= 8'hff;
            squelch_active <= 1'b0;
        end else if (!cfg[F_SQ_EN]) begin
            sq_hist <= 8'hff;
            squelch_active <= 1'b0;
        end else begin
            if (bit_done) sq_hist <= {sq_hist[6:0], bit_good};
            if (sq_pop <= SQ_ON_MAX) squelch_active <= 1'b1;
            else if (sq_pop >= SQ_OFF_MIN) squelch_active <= 1'b0;
        end
    end

    // Data output gate
    assign pass = (state == RAP_AWAKE || state == RAP_RUN) && !squelch_active;
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            data_out <= 1'b0;
        end else begin
            data_out <= pass && data_sync[2];
        end
    end
endmodule
`default_nettype wire

// [logic/rap_pkg.sv]
// Overview of operation
// - Poll bit off stays awake, on polls
// - Sleep time doubles from 10 ms
// - Free-running slow tick times sleep
// - Plain poll sleeps once; host re-arms
// - Good-bit target: 0, 2, 4, 8 bits
// - Eight window codes, four bandwidth variants
// - Oversized window makes every bit bad
// - Enough good bits reopen data output
// - Second bad phase sends device back to sleep
// - High and low phase both checked
// - Edge watchdog returns to sleep, disableable
// - Watchdog 5/5/10/20 ms by bandwidth code
// - Edge interval inside window is bad
// - Two bad pulses or none sleep
// - Squelch on at 4/8, off 7/8
// - Squelch enable bit, default off
// - Desense field drives gain reduction code
// - Slicing level field drives threshold select
// - Fast bandwidth bit, default normal
// - Signal-strength offset bit, default none
// - Bandwidth from pins or configuration word
package rap_pkg;
    // Register byte addresses
    localparam logic [3:0] ADDR_CONFIG = 4'h0;
    localparam logic [3:0] ADDR_STATUS = 4'h4;
    localparam int CFG_W = 20;
    localparam logic [19:0] CFG_RESET = 20'h00078;
    // Field positions in the configuration word
    localparam int F_DES_EN = 0;
    localparam int F_DES_LO = 1;
    localparam int F_BW_LO = 3;
    localparam int F_SLICE_LO = 5;
    localparam int F_BCNT_LO = 7;
    localparam int F_WIN_LO = 9;
    localparam int F_SLEEP_LO = 12;
    localparam int F_POLL = 15;
    localparam int F_FAST = 16;
    localparam int F_SQ_EN = 17;
    localparam int F_WD_DIS = 18;
    localparam int F_RSSI = 19;
    // Timing
    localparam int CLK_MHZ = 100;
    localparam int CYC_PER_US = CLK_MHZ;
    localparam int MS_US = 1000;
    localparam int MS_CYCLES = MS_US * CYC_PER_US;
    localparam logic [10:0] SLEEP_BASE_MS = 11'h00a;
    localparam logic [4:0] WD_MS_FAST = 5'h05;
    localparam logic [4:0] WD_MS_MID = 5'h0a;
    localparam logic [4:0] WD_MS_SLOW = 5'h14;
    localparam logic [1:0] BAD_LIMIT = 2'h2;
    localparam logic [3:0] SQ_ON_MAX = 4'h4;
    localparam logic [3:0] SQ_OFF_MIN = 4'h7;
    // Window times in us: [code][variant], variant 0 for widest bandwidth
    localparam logic [9:0] WIN_US [0:7][0:3] = '{
        '{10'd67, 10'd136, 10'd270, 10'd541},
        '{10'd64, 10'd126, 10'd252, 10'd505},
        '{10'd59, 10'd118, 10'd234, 10'd469},
        '{10'd54, 10'd108, 10'd216, 10'd434},
        '{10'd49, 10'd100, 10'd198, 10'd397},
        '{10'd45, 10'd90, 10'd180, 10'd361},
        '{10'd41, 10'd82, 10'd163, 10'd325},
        '{10'd36, 10'd72, 10'd144, 10'd289}};
    // Polling states, Gray along awake-sleep-check-run
    typedef enum logic [1:0] {
        RAP_AWAKE = 2'b00,
        RAP_SLEEP = 2'b01,
        RAP_CHECK = 2'b11,
        RAP_RUN = 2'b10
    } rap_state_t;
endpackage

// [test/rap_ctrl_chk.sv]
`timescale 1ns/1ps
`default_nettype none
module rap_ctrl_chk #(
    parameter int MS_TICK = 50
) (
    input wire logic ref_clk, // Clock
    input wire logic rst, // Reset
    input wire logic s_axi_awvalid, // AW valid
    input wire logic s_axi_awready, // AW ready
    input wire logic s_axi_wready, // W ready
    input wire logic s_axi_bvalid, // B valid
    input wire logic s_axi_bready, // B ready
    input wire logic s_axi_arready, // AR ready
    input wire logic [31:0] s_axi_rdata, // Read data
    input wire logic s_axi_rvalid, // R valid
    input wire logic s_axi_rready, // R ready
    input wire logic sliced_data, // Sliced input
    input wire logic data_out, // Gated data
    input wire logic rx_awake, // Awake
    input wire logic desense_en, // Desense on
    input wire logic [1:0] desense_code, // Desense step
    input wire logic [1:0] slice_code, // Slice level
    input wire logic fast_bw, // Fast range
    input wire logic rssi_offset_en, // Offset on
    input wire logic squelch_active // Squelch
);
    int unsigned slp_n;
    logic wr_seen;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    // Sleep length, and whether a write landed during the sleep
    always_ff @(posedge ref_clk) begin
        if (rx_awake && !rst) begin
            slp_n <= '0;
            wr_seen <= 1'b0;
        end else begin
            slp_n <= slp_n + 1;
            wr_seen <= wr_seen || rst || (s_axi_awvalid && s_axi_awready);
        end
    end
    chk_sleep_len: assert property (
        $rose(rx_awake) && !wr_seen |-> slp_n >= 9 * MS_TICK) else $error("sleep too short");
    chk_sleep_gate: assert property (
        !rx_awake && !$past(rx_awake) |-> !data_out) else $error("data out while asleep");
    chk_squelch_gate: assert property (
        squelch_active && $past(squelch_active) |-> !data_out) else $error("data out squelched");
    chk_data_delay: assert property (
        data_out |-> $past(sliced_data, 4)) else $error("data out not from input");
    chk_cfg_change: assert property (
        !$stable({desense_en, desense_code, slice_code, fast_bw, rssi_offset_en})
        |-> $past(s_axi_bvalid)) else $error("settings moved without write");
    chk_wr_block: assert property (
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write taken early");
    chk_bvalid_hold: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid dropped");
    chk_rd_block: assert property (
        s_axi_rvalid |-> !s_axi_arready) else $error("read taken early");
    chk_rvalid_hold: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data not held");
endmodule
bind rap_ctrl rap_ctrl_chk #(.MS_TICK(MS_TICK)) u_chk (.*);
`default_nettype wire

// [test/rap_rf_src.sv]
`timescale 1ns/1ps
`default_nettype none
module rap_rf_src (
    input wire logic ref_clk, // Clock
    input wire logic en, // Pulses on
    input wire logic [15:0] ph_cyc, // Phase length
    output logic sliced_data = 1'b0 // Sliced data
);
    logic [15:0] n = 16'h0;
    // Equal high and low phases; low while no carrier
    always @(posedge ref_clk) begin
        if (!en) begin
            n <= 16'h0;
            sliced_data <= 1'b0;
        end else if (n >= ph_cyc - 16'h1) begin
            n <= 16'h0;
            sliced_data <= ~sliced_data;
        end else begin
            n <= n + 16'h1;
        end
    end
endmodule
`default_nettype wire

// [test/tb_rap_ctrl.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_rap_ctrl;
    import rap_pkg::*;
    localparam int MT = 50;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, en = 1'b0;
    logic bw_select_pin_lo = 1'b1, bw_select_pin_hi = 1'b1;
    logic [15:0] ph = 16'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic sliced_data, data_out, rx_awake, desense_en, fast_bw, rssi_offset_en, squelch_active;
    logic [1:0] s_axi_bresp, s_axi_rresp, desense_code, bw_code, slice_code;
    int n_errors = 0;
    int n_tests = 0;
    int t, e;
    rap_ctrl #(.MS_TICK(MT)) DUT (.*);
    rap_rf_src u_src (.ref_clk(ref_clk), .en(en), .ph_cyc(ph), .sliced_data(sliced_data));
    initial forever #5 ref_clk = ~ref_clk;
    // Comparison, reporting and closing
    task automatic check_data(input logic [31:0] g, input logic [31:0] x);
        n_tests++;
        if (g !== x) begin
            n_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, g, x);
        end
    endtask
    task automatic check_resp(input logic [1:0] g, input logic [1:0] x);
        check_data({30'h0, g}, {30'h0, x});
    endtask
    task automatic done(input string s);
        $display("test %s finished, errors so far %0d", s, n_errors);
    endtask
    task automatic results;
        $display("comparisons %0d, mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // Bus master: ready sampled mid-cycle, release by NBA after the edge
    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s,
                          input logic [1:0] x);
        logic ah, wh, bh;
        logic [1:0] r;
        int n;
        bh = 1'b0;
        n = 0;
        @(posedge ref_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!bh && n < 100) begin
            @(negedge ref_clk);
            ah = s_axi_awvalid && s_axi_awready;
            wh = s_axi_wvalid && s_axi_wready;
            bh = s_axi_bvalid && s_axi_bready;
            r = s_axi_bresp;
            @(posedge ref_clk);
            if (ah) s_axi_awvalid <= 1'b0;
            if (wh) s_axi_wvalid <= 1'b0;
            n++;
        end
        s_axi_bready <= 1'b0;
        if (!bh) n_errors++;
        check_resp(r, x);
    endtask
    task automatic axi_rd(input logic [3:0] a, input logic [1:0] x, output logic [31:0] d);
        logic ah, rh;
        logic [1:0] r;
        int n;
        rh = 1'b0;
        n = 0;
        @(posedge ref_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!rh && n < 100) begin
            @(negedge ref_clk);
            ah = s_axi_arvalid && s_axi_arready;
            rh = s_axi_rvalid && s_axi_rready;
            r = s_axi_rresp;
            d = s_axi_rdata;
            @(posedge ref_clk);
            if (ah) s_axi_arvalid <= 1'b0;
            n++;
        end
        s_axi_rready <= 1'b0;
        if (!rh) n_errors++;
        check_resp(r, x);
    endtask
    // Status low field: bandwidth, squelch, loaded, state
    task automatic st(input logic [5:0] x);
        axi_rd(ADDR_STATUS, 2'h0, rd);
        check_data({26'h0, rd[5:0]}, {26'h0, x});
    endtask
    // Wait on awake, data out or squelch; t holds the cycles taken
    task automatic wt(input int k, input logic v, input int mx);
        logic s;
        t = 0;
        do begin
            @(negedge ref_clk);
            t++;
            s = (k == 0) ? rx_awake : (k == 1) ? data_out : squelch_active;
        end while (s !== v && t < mx);
        if (s !== v) n_errors++;
    endtask
    function automatic logic [31:0] outs();
        return {20'h0, rx_awake, desense_en, desense_code, bw_code, slice_code, fast_bw,
                rssi_offset_en, squelch_active, data_out};
    endfunction
    function automatic logic [31:0] cw(input logic p, input logic [2:0] sl, input logic [1:0] bc,
                                       input logic wd, input logic [1:0] bw);
        return {12'h0, 1'b0, wd, 2'h0, p, sl, 3'h7, bc, 2'h3, bw, 3'h0};
    endfunction
    // Hang guard
    initial begin
        #1000000;
        n_errors++;
        results();
    end
    // Test sequence
    initial begin
        repeat (6) @(posedge ref_clk);
        rst <= 1'b0;
        @(negedge ref_clk);
        check_data(outs(), {20'h0, 4'h8, 4'hf, 4'h0});
        @(posedge ref_clk);
        bw_select_pin_lo <= 1'b0;
        repeat (6) @(posedge ref_clk);
        @(negedge ref_clk);
        check_data({30'h0, bw_code}, 32'h2);
        @(posedge ref_clk);
        bw_select_pin_lo <= 1'b1;
        axi_rd(ADDR_CONFIG, 2'h0, rd);
        check_data(rd, 32'h0);
        axi_rd(4'h8, 2'h3, rd);
        axi_wr(4'hc, 32'h0, 4'hf, 2'h3);
        axi_wr(ADDR_STATUS, 32'hffffffff, 4'hf, 2'h0);
        st({2'h3, 2'h0, RAP_AWAKE});
        done("reset");
        axi_wr(ADDR_CONFIG, 32'h0009004f, 4'hf, 2'h0);
        repeat (2) @(posedge ref_clk);
        @(negedge ref_clk);
        check_data(outs(), {20'h0, 4'hf, 4'h6, 4'hc});
        axi_wr(ADDR_CONFIG, 32'h0, 4'h1, 2'h0);
        repeat (2) @(posedge ref_clk);
        @(negedge ref_clk);
        check_data(outs(), {20'h0, 4'h8, 4'h0, 4'hc});
        st({2'h0, 2'h1, RAP_AWAKE});
        done("config");
        e = int'(SLEEP_BASE_MS) * 2 * MT;
        axi_wr(ADDR_CONFIG, cw(1'b1, 3'h1, 2'h0, 1'b0, 2'h3), 4'hf, 2'h0);
        wt(0, 1'b0, 10);
        wt(0, 1'b1, 1200);
        check_data(32'(t >= e - MT && t <= e + 5), 32'h1);
        st({2'h3, 2'h1, RAP_RUN});
        axi_wr(ADDR_CONFIG, cw(1'b1, 3'h1, 2'h0, 1'b0, 2'h3), 4'hf, 2'h0);
        repeat (20) @(posedge ref_clk);
        @(negedge ref_clk);
        check_data({31'h0, rx_awake}, 32'h1);
        axi_wr(ADDR_CONFIG, cw(1'b0, 3'h1, 2'h0, 1'b0, 2'h3), 4'hf, 2'h0);
        axi_wr(ADDR_CONFIG, cw(1'b1, 3'h1, 2'h0, 1'b0, 2'h3), 4'hf, 2'h0);
        wt(0, 1'b0, 10);
        check_data({31'h0, rx_awake}, 32'h0);
        axi_wr(ADDR_CONFIG, cw(1'b0, 3'h1, 2'h0, 1'b0, 2'h3), 4'hf, 2'h0);
        wt(0, 1'b1, 10);
        check_data({31'h0, rx_awake}, 32'h1);
        done("poll");
        @(posedge ref_clk);
        ph <= 16'h0fa0;
        en <= 1'b1;
        axi_wr(ADDR_CONFIG, cw(1'b1, 3'h0, 2'h1, 1'b1, 2'h3), 4'hf, 2'h0);
        wt(0, 1'b0, 10);
        wt(0, 1'b1, 600);
        st({2'h3, 2'h1, RAP_CHECK});
        wt(1, 1'b1, 40000);
        check_data(32'(t > 8000 && t < 40000), 32'h1);
        st({2'h3, 2'h1, RAP_RUN});
        axi_wr(ADDR_CONFIG, cw(1'b0, 3'h0, 2'h1, 1'b1, 2'h3), 4'hf, 2'h0);
        done("good bits");
        ph <= 16'h03e8;
        axi_wr(ADDR_CONFIG, cw(1'b1, 3'h0, 2'h1, 1'b1, 2'h3), 4'hf, 2'h0);
        wt(0, 1'b0, 10);
        wt(0, 1'b1, 600);
        wt(0, 1'b0, 6000);
        check_data(32'(t < 6000), 32'h1);
        st({2'h3, 2'h1, RAP_SLEEP});
        en <= 1'b0;
        axi_wr(ADDR_CONFIG, cw(1'b0, 3'h0, 2'h1, 1'b1, 2'h3), 4'hf, 2'h0);
        done("bad bits");
        for (int i = 0; i < 2; i++) begin
            e = (i == 0 ? int'(WD_MS_FAST) : int'(WD_MS_SLOW)) * MT;
            axi_wr(ADDR_CONFIG, cw(1'b1, 3'h0, 2'h1, 1'b0, 2'(3 - 3 * i)), 4'hf, 2'h0);
            wt(0, 1'b0, 10);
            wt(0, 1'b1, 600);
            wt(0, 1'b0, 1500);
            check_data(32'(t >= e - MT && t <= e + 5), 32'h1);
            axi_wr(ADDR_CONFIG, cw(1'b0, 3'h0, 2'h1, 1'b0, 2'(3 - 3 * i)), 4'hf, 2'h0);
        end
        done("watchdog");
        ph <= 16'h01f4;
        en <= 1'b1;
        axi_wr(ADDR_CONFIG, cw(1'b0, 3'h0, 2'h0, 1'b0, 2'h3) | 32'h20000, 4'hf, 2'h0);
        wt(2, 1'b1, 20000);
        // Data out follows the squelch flag one cycle later
        @(negedge ref_clk);
        check_data({30'h0, squelch_active, data_out}, 32'h2);
        done("squelch");
        // Reset in mid-run brings back defaults and pin bandwidth
        @(posedge ref_clk);
        rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        @(negedge ref_clk);
        check_data(outs(), {20'h0, 4'h8, 4'hf, 4'h0});
        st({2'h3, 2'h0, RAP_AWAKE});
        done("mid reset");
        results();
    end
endmodule
`default_nettype wire
